//--- edm_mapper.sv
// module: external data memory address mapper and strobe timing
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module edm_mapper
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic reqValid,
  input wire edm_pkg::edm_req_s req,
  output logic reqDone,
  output logic [7:0] rdData,
  output logic [11:0] ramAddr,
  output logic ramWe,
  output logic ramRe,
  output logic [7:0] ramWrData,
  input wire logic [7:0] ramRdData,
  output edm_pkg::edm_bus_s bus,
  input wire logic [7:0] busDataIn
);
  logic [7:0] memory_interface_config;
  logic [7:0] external_page_select;
  logic [7:0] external_memory_timing_control;
  logic [15:0] effAddr;
  logic offChip;
  logic ramPending;
  logic [7:0] busSync1;
  logic [7:0] busSync2;
  logic [3:0] count;
  edm_pkg::edm_state_e state;
  edm_pkg::edm_state_e next_state;
  edm_pkg::edm_req_s held;
  logic busy;
  logic wbHit;
  logic [7:0] wbAddr;
  logic [1:0] setupField;
  logic [3:0] pulseField;
  logic [1:0] holdField;
  logic strobeEnd1;
  logic strobeEnd2;

  function automatic logic [15:0] eff_addr(input edm_pkg::edm_req_s r, input logic [7:0] page);
    logic [7:0] idx;
    idx = r.indexSel ? r.indexOne : r.indexZero;
    eff_addr = r.wide ? r.dataPointer : {page, idx};
  endfunction : eff_addr

  assign wbAddr = wb_adr_i[7:0];
  assign wbHit = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // single wait state: ack one cycle after strobe, dropped next cycle
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wbHit;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      memory_interface_config <= edm_pkg::RST_CONFIG;
      external_page_select <= edm_pkg::RST_PAGE;
      external_memory_timing_control <= edm_pkg::RST_TIMING;
    end
    else if (wbHit && wb_we_i && wb_sel_i[0])
    begin
      case (wbAddr)
        edm_pkg::ADR_CONFIG: memory_interface_config <= wb_dat_i[7:0];
        edm_pkg::ADR_PAGE: external_page_select <= wb_dat_i[7:0];
        edm_pkg::ADR_TIMING: external_memory_timing_control <= wb_dat_i[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      wb_dat_o <= 32'h0;
    else if (wbHit && !wb_we_i)
    begin
      case (wbAddr)
        edm_pkg::ADR_CONFIG: wb_dat_o <= {24'h0, memory_interface_config};
        edm_pkg::ADR_PAGE: wb_dat_o <= {24'h0, external_page_select};
        edm_pkg::ADR_TIMING: wb_dat_o <= {24'h0, external_memory_timing_control};
        edm_pkg::ADR_STATUS: wb_dat_o <= {29'h0, state};
        default: wb_dat_o <= 32'h0;
      endcase
    end
  end

  assign busy = (state != edm_pkg::ST_IDLE) || ramPending;
  assign effAddr = eff_addr(req, external_page_select);

  // mode decode; unsupported modes fall back to on-chip only
  always_comb
  begin
    offChip = 1'b0;
    if (memory_interface_config[edm_pkg::MODE_HI:edm_pkg::MODE_LO] == edm_pkg::MODE_SPLIT)
    begin
      offChip = (effAddr >= edm_pkg::ONCHIP_LIMIT);
    end
    // mode 00 never leaves the chip
  end

  // on-chip access: one cycle to present, result next cycle
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      ramPending <= 1'b0;
      ramAddr <= 12'h0;
      ramWe <= 1'b0;
      ramRe <= 1'b0;
      ramWrData <= 8'h0;
    end
    else
    begin
      ramWe <= 1'b0;
      ramRe <= 1'b0;
      ramPending <= 1'b0;
      if (reqValid && !busy && !offChip)
      begin
        ramAddr <= effAddr[11:0] & edm_pkg::ONCHIP_MASK;
        ramWe <= req.write;
        ramRe <= !req.write;
        ramWrData <= req.wrData;
        ramPending <= 1'b1;
      end
    end
  end

  assign setupField = external_memory_timing_control[edm_pkg::SETUP_HI:edm_pkg::SETUP_LO];
  assign pulseField = external_memory_timing_control[edm_pkg::PULSE_HI:edm_pkg::PULSE_LO];
  assign holdField = external_memory_timing_control[edm_pkg::HOLD_HI:edm_pkg::HOLD_LO];

  // off-chip strobe sequencer; a zero setup or hold field skips its state
  always_comb
  begin
    next_state = state;
    case (state)
      edm_pkg::ST_IDLE:
        if (reqValid && !ramPending && offChip)
        begin
          // no setup state for field zero
          if (setupField == 2'h0)
            next_state = edm_pkg::ST_STROBE;
          else
            next_state = edm_pkg::ST_SETUP;
        end
      edm_pkg::ST_SETUP:
        if (count == 4'h0)
          next_state = edm_pkg::ST_STROBE;
      edm_pkg::ST_STROBE:
        if (count == 4'h0)
        begin
          // no hold state for field zero
          if (holdField == 2'h0)
            next_state = edm_pkg::ST_DONE;
          else
            next_state = edm_pkg::ST_HOLD;
        end
      edm_pkg::ST_HOLD:
        if (count == 4'h0)
          next_state = edm_pkg::ST_DONE;
      edm_pkg::ST_DONE:
        if (count == 4'h0)
          next_state = edm_pkg::ST_IDLE;
      default:
        next_state = edm_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      state <= edm_pkg::ST_IDLE;
    else
      state <= next_state;
  end

  // counter loaded on every state change, then counts down to zero
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      count <= 4'h0;
    else if (next_state != state)
    begin
      case (next_state)
        edm_pkg::ST_SETUP: count <= {2'h0, setupField} - 4'h1;
        edm_pkg::ST_STROBE: count <= pulseField;
        edm_pkg::ST_HOLD: count <= {2'h0, holdField} - 4'h1;
        // read data still crossing the synchroniser
        edm_pkg::ST_DONE: count <= edm_pkg::DONE_WAIT;
        default: count <= 4'h0;
      endcase
    end
    else if (count != 4'h0)
      count <= count - 4'h1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      held <= '0;
    else if (state == edm_pkg::ST_IDLE && reqValid)
      held <= req;
  end

  // pin drive; with zero setup the strobe falls with the address
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      bus.addr <= 16'h0;
      bus.addrOe_n <= 16'hFFFF;
      bus.dataOut <= 8'h0;
      bus.dataOe_n <= 1'b1;
      bus.wr_n <= 1'b1;
      bus.rd_n <= 1'b1;
    end
    else if (next_state == edm_pkg::ST_IDLE || next_state == edm_pkg::ST_DONE)
    begin
      bus.addrOe_n <= 16'hFFFF;
      bus.dataOe_n <= 1'b1;
      bus.wr_n <= 1'b1;
      bus.rd_n <= 1'b1;
    end
    else if (state == edm_pkg::ST_IDLE)
    begin
      bus.addr <= effAddr;
      bus.dataOut <= req.wrData;
      bus.dataOe_n <= !req.write;
      // wide move drives all lines; narrow leaves high lines alone
      bus.addrOe_n <= req.wide ? 16'h0000 : 16'hFF00;
      bus.wr_n <= !(next_state == edm_pkg::ST_STROBE && req.write);
      bus.rd_n <= !(next_state == edm_pkg::ST_STROBE && !req.write);
    end
    else
    begin
      bus.wr_n <= !(next_state == edm_pkg::ST_STROBE && held.write);
      bus.rd_n <= !(next_state == edm_pkg::ST_STROBE && !held.write);
    end
  end

  // read data pins are asynchronous to the core
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      busSync1 <= 8'h0;
      busSync2 <= 8'h0;
    end
    else
    begin
      busSync1 <= busDataIn;
      busSync2 <= busSync1;
    end
  end

  // last strobe cycle reaches the second flop two edges later
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      strobeEnd1 <= 1'b0;
      strobeEnd2 <= 1'b0;
    end
    else
    begin
      strobeEnd1 <= (state == edm_pkg::ST_STROBE) && (next_state != edm_pkg::ST_STROBE);
      strobeEnd2 <= strobeEnd1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      reqDone <= 1'b0;
      rdData <= 8'h0;
    end
    else
    begin
      reqDone <= ramPending || (state == edm_pkg::ST_DONE && count == 4'h0);
      if (ramPending)
        rdData <= ramRdData;
      else if (strobeEnd2 && !held.write)
        rdData <= busSync2;
    end
  end
endmodule : edm_mapper
`default_nettype wire

//--- edm_mapper_properties.sv
// checker: mapping and strobe timing at the mapper ports
`timescale 1ns/1ps
`default_nettype none
module edm_mapper_properties
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire edm_pkg::edm_req_s req,
  input wire logic reqDone,
  input wire logic [11:0] ramAddr,
  input wire logic ramWe,
  input wire logic ramRe,
  input wire edm_pkg::edm_bus_s bus
);
  logic [7:0] tmg;
  logic [4:0] lowCnt;
  wire logic strobeLow = !bus.wr_n || !bus.rd_n;
  // shadow of the timing register, seen only through bus writes
  always_ff @(posedge ref_clk)
    if (reset)
      tmg <= edm_pkg::RST_TIMING;
    else if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[7:0] == edm_pkg::ADR_TIMING)
      tmg <= wb_dat_i[7:0];
  always_ff @(posedge ref_clk)
    lowCnt <= (reset || !strobeLow) ? 5'h0 : lowCnt + 5'h1;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_wb_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_ram_done: assert property (ramWe || ramRe |=> reqDone)
    else $error("on-chip move not done");
  a_wide_addr: assert property (!bus.wr_n && req.wide |->
    bus.addr == req.dataPointer && bus.addrOe_n == 16'h0)
    else $error("wide address wrong");
  a_narrow_high: assert property (strobeLow && !req.wide |->
    bus.addrOe_n == 16'hFF00)
    else $error("narrow upper lines driven");
  a_narrow_low: assert property (strobeLow && !req.wide |->
    bus.addr[7:0] == (req.indexSel ? req.indexOne : req.indexZero))
    else $error("narrow low address wrong");
  a_split_bound: assert property ($rose(strobeLow) && req.wide |->
    req.dataPointer >= edm_pkg::ONCHIP_LIMIT)
    else $error("off-chip below boundary");
  a_ram_fold: assert property ((ramWe || ramRe) && req.wide |->
    ramAddr == req.dataPointer[11:0])
    else $error("on-chip address wrong");
  a_pulse_width: assert property ($fell(strobeLow) |->
    lowCnt == {1'b0, tmg[5:2]} + 5'h1)
    else $error("strobe width wrong");
endmodule : edm_mapper_properties
`default_nettype wire

//--- edm_offchip_mem.sv
// model: off-chip asynchronous byte memory
`timescale 1ns/1ps
`default_nettype none
module edm_offchip_mem
(
  input wire logic ref_clk,
  input wire edm_pkg::edm_bus_s bus,
  output logic [7:0] busDataIn
);
  logic [7:0] mem [0:65535];
  logic [7:0] lastRd;
  // undriven lines read as 0, standing in for the port state
  wire logic [15:0] a = bus.addr & ~bus.addrOe_n;
  // write lands while the strobe is low, before the address is released
  always @(posedge ref_clk)
    if (!bus.wr_n)
      mem[a] <= bus.dataOut;
  always @(posedge ref_clk)
    if (!bus.rd_n)
      lastRd <= mem[a];
  // released bus shows the inverse so stale data never looks valid
  assign busDataIn = bus.rd_n ? ~lastRd : mem[a];
endmodule : edm_offchip_mem
`default_nettype wire

//--- edm_pkg.sv
// package: constants and types of the external data memory mapper
// Contract
// - mode 00 sends every external data move to on-chip RAM with no off-chip cycle.
// - in mode 00 the effective address folds onto on-chip RAM modulo 4k.
// - an 8-bit move in mode 00 takes its high byte from the page register, low from the index.
// - a 16-bit move in mode 00 uses the full data pointer as the address.
// - in mode 01 addresses below 4k go to on-chip RAM.
// - in mode 01 addresses at or above 4k go to the off-chip bus.
// - in mode 01 an 8-bit move decides by the page register and drives A[7:0] from the index.
// - in mode 01 an off-chip 8-bit move leaves A[15:8] undriven.
// - in mode 01 a 16-bit move decides by comparing the data pointer with 4k.
// - in mode 01 an off-chip 16-bit move drives A[15:0] from the data pointer.
package edm_pkg;
  localparam logic [7:0] ADR_CONFIG = 8'h00;
  localparam logic [7:0] ADR_PAGE = 8'h04;
  localparam logic [7:0] ADR_TIMING = 8'hA1;
  localparam logic [7:0] ADR_STATUS = 8'h08;
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_PAGE = 8'h00;
  localparam logic [7:0] RST_TIMING = 8'hFF;
  localparam int MODE_HI = 3;
  localparam int MODE_LO = 2;
  localparam int SETUP_HI = 7;
  localparam int SETUP_LO = 6;
  localparam int PULSE_HI = 5;
  localparam int PULSE_LO = 2;
  localparam int HOLD_HI = 1;
  localparam int HOLD_LO = 0;
  localparam logic [1:0] MODE_INTERNAL = 2'h0;
  localparam logic [1:0] MODE_SPLIT = 2'h1;
  localparam logic [15:0] ONCHIP_LIMIT = 16'h1000;
  localparam logic [11:0] ONCHIP_MASK = 12'hFFF;
  localparam logic [3:0] DONE_WAIT = 4'h1;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'h0,
    ST_SETUP = 3'h1,
    ST_STROBE = 3'h3,
    ST_HOLD = 3'h2,
    ST_DONE = 3'h6
  } edm_state_e;

  // one move request from the core
  typedef struct packed
  {
    logic write;
    logic wide;
    logic indexSel;
    logic [15:0] dataPointer;
    logic [7:0] indexZero;
    logic [7:0] indexOne;
    logic [7:0] wrData;
  } edm_req_s;

  // off-chip bus pins, active-low strobes
  typedef struct packed
  {
    logic [15:0] addr;
    logic [15:0] addrOe_n;
    logic [7:0] dataOut;
    logic dataOe_n;
    logic wr_n;
    logic rd_n;
  } edm_bus_s;
endpackage : edm_pkg

//--- tb_edm_mapper.sv
// bench: register, on-chip and off-chip move checks
`timescale 1ns/1ps
`default_nettype none
module tb_edm_mapper;
  logic ref_clk, reset, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, reqValid, reqDone, ramWe, ramRe;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o;
  logic [3:0] wb_sel_i;
  logic [7:0] rdData, ramWrData, busDataIn, rd;
  logic [11:0] ramAddr, ra;
  logic [7:0] tv [3] = '{8'h00, 8'h4D, 8'hFF};
  edm_pkg::edm_req_s req;
  edm_pkg::edm_bus_s bus;
  int failures, check_count, su, lo, ho, cyc, ram;
  wire logic [7:0] ramRdData = ramAddr[7:0] ^ 8'h5A;
  edm_mapper i_edm_mapper (.ref_clk, .reset, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i,
    .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .reqValid, .req, .reqDone, .rdData,
    .ramAddr, .ramWe, .ramRe, .ramWrData, .ramRdData, .bus, .busDataIn);
  edm_offchip_mem i_edm_offchip_mem (.ref_clk, .bus, .busDataIn);
  initial
  begin
    ref_clk = 0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= we;
    wb_adr_i <= {24'h0, a};
    wb_dat_i <= {24'h0, d};
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask : wb
  // request held one cycle; req itself stays until done
  task automatic mv(input logic w, wd, ix, input logic [15:0] dp, input logic [7:0] i, d);
    @(posedge ref_clk);
    req <= '{w, wd, ix, dp, ix ? ~i : i, ix ? i : ~i, d};
    reqValid <= 1;
    @(posedge ref_clk);
    reqValid <= 0;
    {su, lo, ho, cyc, ram} = '0;
    do
    begin
      @(negedge ref_clk);
      cyc++;
      if (ramWe || ramRe)
      begin
        ram++;
        ra = ramAddr;
      end
      if (!bus.wr_n || !bus.rd_n)
        lo++;
      else if (!bus.addrOe_n[0])
      begin
        if (lo == 0)
          su++;
        else
          ho++;
      end
    end
    while (reqDone !== 1'b1);
    rd = rdData;
  endtask : mv
  task automatic complete_run();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    complete_run();
  end
  initial
  begin
    {reset, wb_we_i, wb_cyc_i, wb_stb_i, reqValid, wb_adr_i, wb_dat_i, req} = '0;
    reset = 1;
    wb_sel_i = 4'hF;
    repeat (3) @(posedge ref_clk);
    reset <= 0;
    wb(0, edm_pkg::ADR_TIMING, 8'h00);
    chk("timing", 8'hFF, rd);
    wb(0, 8'h40, 8'h00);
    chk("unmapped", 8'h00, rd);
    wb(0, edm_pkg::ADR_STATUS, 8'h00);
    chk("status", 8'h00, rd);
    wb(1, edm_pkg::ADR_PAGE, 8'h13);
    mv(1, 1, 0, 16'h2345, 8'h00, 8'hA5);
    chk("fold", 12'h345, ra);
    chk("strobe", 0, lo + su);
    chk("ramwr", 8'hA5, ramWrData);
    mv(0, 0, 1, 16'h0000, 8'h77, 8'h00);
    chk("page", 12'h377, ra);
    chk("ramrd", 8'h2D, rd);
    wb(1, edm_pkg::ADR_CONFIG, 8'h04);
    foreach (tv[k])
    begin
      wb(1, edm_pkg::ADR_TIMING, tv[k]);
      mv(1, 1, 0, 16'h1000 + 16'(k), 8'h00, 8'hC0 + 8'(k));
      chk("setup", tv[k][7:6], su);
      chk("pulse", tv[k][5:2] + 1, lo);
      chk("hold", tv[k][1:0], ho);
      chk("offram", 0, ram);
    end
    foreach (tv[k])
    begin
      mv(0, 1, 0, 16'h1000 + 16'(k), 8'h00, 8'h00);
      chk("offrd", 8'hC0 + 8'(k), rd);
    end
    mv(0, 1, 0, 16'h0FFF, 8'h00, 8'h00);
    chk("edge", 12'hFFF, ra);
    mv(1, 0, 0, 16'h0000, 8'h55, 8'h3C);
    mv(0, 0, 1, 16'h0000, 8'h55, 8'h00);
    chk("narrow", 8'h3C, rd);
    wb(1, edm_pkg::ADR_PAGE, 8'h0F);
    mv(0, 0, 0, 16'h0000, 8'h66, 8'h00);
    chk("low page", 12'hF66, ra);
    complete_run();
  end
endmodule : tb_edm_mapper
bind edm_mapper edm_mapper_properties i_edm_mapper_properties (.ref_clk, .reset, .wb_adr_i,
  .wb_dat_i, .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .req, .reqDone, .ramAddr,
  .ramWe, .ramRe, .bus);
`default_nettype wire
